// ===== hstp_master.sv
// Two-wire bus host that writes and reads the registers of a target device.
`default_nettype none

// Notes on behaviour
// - The bus runs at fast-mode rate, 400 kbit/s, which also serves 100 kbit/s targets.
// - Data changes only while the clock is low, and each bit gets one clock pulse.
// - Start is a data fall while the clock is high and stop is a data rise while it is high.
// - Only this host makes start and stop, and the bus is busy from start to stop.
// - Every byte is eight bits and a transfer carries any number of bytes; here 1 to 256 data bytes, i_cmd_len plus one.
// - Bytes go most significant bit first and each one is followed by an acknowledge bit.
// - The host makes every clock pulse, the ninth acknowledge pulse included.
// - The sender releases data in the ninth pulse and a high level there ends the transfer.
// - A start is followed by the seven-bit target address and a direction bit, 0 write.
// - A read sends the register address, restarts in read direction, and refuses the last byte.
module hstp_master (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_read,
  input wire logic [hstp_pkg::HSTP_BYTE_W-1:0] i_cmd_reg,
  input wire logic [hstp_pkg::HSTP_BYTE_W-1:0] i_cmd_len,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [hstp_pkg::HSTP_BYTE_W-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [hstp_pkg::HSTP_BYTE_W-1:0] o_rd_data,
  output logic o_done,
  output logic o_nack,
  output logic o_busy,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe
);
  import hstp_pkg::*;

  hstp_state_t st_r;
  hstp_stage_t stg_r;
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [7:0] cnt_r;
  logic [1:0] q_r;
  logic [3:0] bitn_r;
  logic [7:0] sh_r;
  logic [7:0] reg_r;
  logic [7:0] len_r;
  logic [7:0] left_r;
  logic [7:0] rd_data_r;
  logic rnw_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic ack_fail_r;
  logic nack_r;
  logic done_r;
  logic rd_valid_r;
  logic fifo_valid;
  logic [7:0] fifo_data;

  // Both pins come from outside; two flops before anything looks at them.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_sync_r <= HSTP_SYNC_RST;
      sda_sync_r <= HSTP_SYNC_RST;
    end else begin
      scl_sync_r <= {scl_sync_r[0], i_scl};
      sda_sync_r <= {sda_sync_r[0], i_sda};
    end
  end

  wire scl_s = scl_sync_r[1];
  wire sda_s = sda_sync_r[1];

  // Phase decode for the current bit or bus condition.
  wire last_bit = (bitn_r == HSTP_ACK_BIT);
  wire tx_now = (stg_r != STG_RDATA);
  wire in_bit = (st_r == ST_BIT);
  wire byte_end = in_bit && (q_r == 2'd3) && last_bit;
  wire more_rd = (left_r != HSTP_BYTE_RST);

  // Released clock that still reads low means the target is stretching it.
  wire stretch = (st_r != ST_IDLE) && (q_r == 2'd2) && !scl_oe_r && !scl_s;

  // A write byte is due next unless the target has just refused.
  wire want_load = !ack_fail_r && (((stg_r == STG_REG) && !rnw_r) ||
                   ((stg_r == STG_WDATA) && more_rd));

  // The clock stays high after the acknowledge while the buffer is dry, and low while the reader is slow.
  wire fifo_wait = byte_end && want_load && !fifo_valid;
  wire rd_wait = in_bit && (stg_r == STG_RDATA) && last_bit && (q_r == 2'd0) && rd_valid_r;
  wire hold = stretch || fifo_wait || rd_wait;
  wire tick = (cnt_r == HSTP_QTR_CYC - 8'd1) && !hold;
  wire pop = tick && byte_end && want_load;
  wire capture = tick && in_bit && (q_r == 2'd0) && last_bit && (stg_r == STG_RDATA);

  // Write bytes wait here until the sequencer pulls them off.
  hstp_fifo #(
    .WIDTH(HSTP_BYTE_W),
    .DEPTH(HSTP_FIFO_DEPTH)
  ) u_wr_fifo (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_in_valid(i_wr_valid),
    .o_in_ready(o_wr_ready),
    .i_in_data(i_wr_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_data)
  );

  // Level put on data at the start of a bit: data bit, or our acknowledge.
  wire sda_drive = last_bit ? (!tx_now && more_rd) : (tx_now && !sh_r[7]);

  assign o_cmd_ready = (st_r == ST_IDLE);
  assign o_busy = (st_r != ST_IDLE);
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = scl_oe_r;
  assign o_sda_oe = sda_oe_r;
  assign o_rd_valid = rd_valid_r;
  assign o_rd_data = rd_data_r;
  assign o_done = done_r;
  assign o_nack = nack_r;

  // Quarter-phase timer; it freezes on a stretched clock, a dry buffer or a slow reader.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= HSTP_CNT_RST;
    end else if ((st_r == ST_IDLE) || tick) begin
      cnt_r <= HSTP_CNT_RST;
    end else if (!hold) begin
      cnt_r <= cnt_r + 8'd1;
    end
  end

  // Read byte hand-off; a new byte is only captured once the old one is gone.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_valid_r <= 1'b0;
    end else if (capture) begin
      rd_valid_r <= 1'b1;
    end else if (i_rd_ready) begin
      rd_valid_r <= 1'b0;
    end
  end

  // Bus sequencer. Every bus action happens on a quarter tick so that data
  // never moves in the same quarter in which the clock is released.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= ST_IDLE;
      stg_r <= STG_ADDRW;
      q_r <= 2'd0;
      bitn_r <= HSTP_BITN_RST;
      sh_r <= HSTP_BYTE_RST;
      reg_r <= HSTP_BYTE_RST;
      len_r <= HSTP_BYTE_RST;
      left_r <= HSTP_BYTE_RST;
      rd_data_r <= HSTP_BYTE_RST;
      rnw_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ack_fail_r <= 1'b0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (i_cmd_valid) begin
            st_r <= ST_START;
            stg_r <= STG_ADDRW;
            rnw_r <= i_cmd_read;
            reg_r <= i_cmd_reg;
            len_r <= i_cmd_len;
            q_r <= 2'd0;
            nack_r <= 1'b0;
          end
        end
        ST_START: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            case (q_r)
              2'd0: sda_oe_r <= 1'b0;
              2'd1: scl_oe_r <= 1'b0;
              2'd2: sda_oe_r <= 1'b1;
              default: begin
                scl_oe_r <= 1'b1;
                st_r <= ST_BIT;
                bitn_r <= HSTP_BITN_RST;
                // Own target address, then the direction bit.
                sh_r <= {HSTP_DEV_ADDR, (stg_r == STG_ADDRR) ? HSTP_DIR_READ
                                                             : HSTP_DIR_WRITE};
              end
            endcase
          end
        end
        ST_BIT: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            case (q_r)
              2'd0: begin
                sda_oe_r <= sda_drive;
                if (capture) begin
                  rd_data_r <= sh_r;
                end
              end
              2'd1: scl_oe_r <= 1'b0;
              2'd2: begin
                if (last_bit) begin
                  ack_fail_r <= tx_now && sda_s;
                end else begin
                  sh_r <= {sh_r[6:0], sda_s};
                end
              end
              default: begin
                scl_oe_r <= 1'b1;
                if (!last_bit) begin
                  bitn_r <= bitn_r + 4'd1;
                end else begin
                  bitn_r <= HSTP_BITN_RST;
                  if (tx_now && ack_fail_r) begin
                    // Refused address or byte: give the bus back.
                    st_r <= ST_STOP;
                    nack_r <= 1'b1;
                  end else begin
                    case (stg_r)
                      STG_ADDRW: begin
                        stg_r <= STG_REG;
                        sh_r <= reg_r;
                      end
                      STG_REG: begin
                        if (rnw_r) begin
                          st_r <= ST_START;
                          stg_r <= STG_ADDRR;
                        end else begin
                          stg_r <= STG_WDATA;
                          sh_r <= fifo_data;
                          left_r <= len_r;
                        end
                      end
                      STG_WDATA: begin
                        // The target steps its pointer, so bytes just follow.
                        if (!more_rd) begin
                          st_r <= ST_STOP;
                        end else begin
                          sh_r <= fifo_data;
                          left_r <= left_r - 8'd1;
                        end
                      end
                      STG_ADDRR: begin
                        stg_r <= STG_RDATA;
                        left_r <= len_r;
                      end
                      default: begin
                        if (!more_rd) begin
                          st_r <= ST_STOP;
                        end else begin
                          left_r <= left_r - 8'd1;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            case (q_r)
              2'd0: sda_oe_r <= 1'b1;
              2'd1: scl_oe_r <= 1'b0;
              2'd2: sda_oe_r <= 1'b0;
              default: begin
                st_r <= ST_IDLE;
                done_r <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Checks on the bus behaviour, all in the core clock domain.
  default clocking ast_cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  // Data holds still while the clock is released during a bit.
  AST_SDA_STABLE_HIGH: assert property (
    (in_bit && !scl_oe_r && !$rose(in_bit)) |-> $stable(o_sda_oe))
    else $error("data moved while the clock was high");

  // Start pulls data low only with the clock released.
  AST_START_EDGE: assert property (
    ((st_r == ST_START) && $rose(o_sda_oe)) |-> !o_scl_oe)
    else $error("start made with clock low");

  // Stop releases data only with the clock released, then the bus goes idle.
  AST_STOP_EDGE: assert property (
    ((st_r == ST_STOP) && $fell(o_sda_oe)) |-> (!o_scl_oe ##[1:30] o_cmd_ready))
    else $error("stop not followed by idle");

  // Bits of a byte count up one at a time to the acknowledge slot.
  AST_BIT_STEP: assert property (
    (tick && in_bit && (q_r == 2'd3) && !last_bit) |=> (bitn_r == $past(bitn_r) + 4'd1))
    else $error("bit counter skipped");

  // The bit put on the wire is the top of the shifter.
  AST_MSB_FIRST: assert property (
    (tick && in_bit && (q_r == 2'd0) && !last_bit && tx_now) |=> (o_sda_oe == !$past(sh_r[7])))
    else $error("wrong bit order");

  // While the clock is stretched the phase does not advance.
  AST_STRETCH_WAIT: assert property (
    stretch |=> (q_r == 2'd2))
    else $error("phase advanced under a held clock");

  // As sender we release data for the whole acknowledge slot.
  AST_ACK_RELEASE: assert property (
    (in_bit && last_bit && tx_now && (q_r != 2'd0)) |-> !o_sda_oe)
    else $error("data held in acknowledge slot");

  // The direction bit is low for the write address and high for the read one.
  AST_DIR_BIT: assert property (
    (in_bit && (bitn_r == 4'd7) && (q_r == 2'd2) &&
     ((stg_r == STG_ADDRW) || (stg_r == STG_ADDRR))) |-> (o_sda_oe == (stg_r == STG_ADDRW)))
    else $error("wrong direction bit");

  // A refused byte leads to stop and a raised refusal flag.
  AST_NACK_STOP: assert property (
    (tick && byte_end && tx_now && ack_fail_r) |=> ((st_r == ST_STOP) && o_nack))
    else $error("refusal not followed by stop");

  // The last read byte is refused, the others acknowledged.
  AST_LAST_READ: assert property (
    (in_bit && (stg_r == STG_RDATA) && last_bit && (q_r == 2'd2)) |-> (o_sda_oe == more_rd))
    else $error("wrong acknowledge on read");

  // Main scenarios.
  COV_WRITE_DONE: cover property (done_r && !nack_r && !rnw_r);
  COV_READ_DONE: cover property (done_r && !nack_r && rnw_r);
  COV_REFUSED: cover property (done_r && nack_r);
  COV_STRETCH: cover property (stretch [*3]);

endmodule : hstp_master

`default_nettype wire

// ===== hstp_pkg.sv
// Shared constants and types for the two-wire bus host controller.
`default_nettype none

package hstp_pkg;

  // Core clock rate and the fastest bus rate we drive.
  localparam int unsigned HSTP_CORE_KHZ = 40000;
  localparam int unsigned HSTP_SCL_KBPS = 400;

  // One bus bit is four quarter phases; a quarter rounds up to whole cycles.
  localparam logic [7:0] HSTP_QTR_CYC =
    8'((HSTP_CORE_KHZ + 4 * HSTP_SCL_KBPS - 1) / (4 * HSTP_SCL_KBPS));

  // Byte geometry: eight data bits and one acknowledge slot.
  localparam int unsigned HSTP_BYTE_W = 8;
  localparam logic [3:0] HSTP_ACK_BIT = 4'h8;

  // Seven-bit target address of the device on the bus.
  localparam logic [6:0] HSTP_DEV_ADDR = 7'h6b;

  // Direction bit values that follow the target address.
  localparam logic HSTP_DIR_WRITE = 1'b0;
  localparam logic HSTP_DIR_READ = 1'b1;

  // Write data buffer depth.
  localparam int unsigned HSTP_FIFO_DEPTH = 16;

  // Values after reset.
  localparam logic [7:0] HSTP_BYTE_RST = 8'h00;
  localparam logic [7:0] HSTP_CNT_RST = 8'h00;
  localparam logic [3:0] HSTP_BITN_RST = 4'h0;
  localparam logic [1:0] HSTP_SYNC_RST = 2'h3;

  // Bus sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_STOP
  } hstp_state_t;

  // Which byte of a transfer is on the wire.
  typedef enum logic [2:0] {
    STG_ADDRW,
    STG_REG,
    STG_WDATA,
    STG_ADDRR,
    STG_RDATA
  } hstp_stage_t;

endpackage : hstp_pkg

`default_nettype wire

// ===== hstp_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
`default_nettype none

module hstp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  import hstp_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};
  localparam logic [AW:0] PTR_RST = '0;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;

  // An extra pointer bit tells a full buffer from an empty one.
  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_r[rd_ptr_r[AW-1:0]];

  // Storage carries no reset; only the pointers define what is valid.
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end

  // Pointer update.
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_r <= PTR_RST;
      rd_ptr_r <= PTR_RST;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PTR_ONE;
      end
    end
  end

endmodule : hstp_fifo

`default_nettype wire

// ===== hstp_target_model.sv
// Behavioural two-wire register target with nine registers, the far end of the host.
`default_nettype none

module hstp_target_model #(
  parameter logic [6:0] DEV_ADDR = 7'h6b,
  parameter int unsigned STRETCH_NS = 3000
) (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_stretch,
  output logic o_scl_oe,
  output logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [0:8];
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic sel;
  logic mack;
  int bitn;
  int stage;

  // Open-drain outputs start released so the pull-ups hold both lines high.
  initial begin
    sel = 1'b0;
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
    foreach (regs[i]) regs[i] = 8'h00;
  end

  // Start and stop are honoured at any moment, even in the middle of a byte.
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      sel = 1'b1;
      stage = 0;
      bitn = -1;
      o_sda_oe = 1'b0;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl === 1'b1) begin
      sel = 1'b0;
      o_sda_oe = 1'b0;
    end
  end

  // Bits are taken while the clock is high, most significant first.
  always @(posedge i_scl) begin
    if (sel && bitn >= 0 && bitn < 8) sh = {sh[6:0], i_sda};
    else if (sel && bitn == 8) mack = !i_sda;
  end

  // Data changes only on the falling clock; stretching holds the clock after an ack.
  always @(negedge i_scl) begin
    if (sel) begin
      bitn = bitn + 1;
      if (bitn == 8 && stage == 0) begin
        sel = (sh[7:1] == DEV_ADDR);
        o_sda_oe = sel;
        stage = sh[0] ? 3 : 1;
      end else if (bitn == 8 && stage == 1) begin
        sel = (sh <= 8'h08);
        o_sda_oe = sel;
        ptr = sh;
        stage = 2;
      end else if (bitn == 8 && stage == 2) begin
        o_sda_oe = (ptr <= 8'h08);
        if (ptr <= 8'h08) regs[ptr[3:0]] = sh;
        ptr = ptr + 8'h01;
      end else if (bitn == 8) begin
        o_sda_oe = 1'b0;
      end else if (bitn == 9) begin
        o_sda_oe = 1'b0;
        bitn = 0;
        if (stage == 3) begin
          sel = mack;
          tx = (ptr <= 8'h08) ? regs[ptr[3:0]] : 8'hff;
          if (mack) ptr = ptr + 8'h01;
          o_sda_oe = mack & !tx[7];
        end
        if (i_stretch) begin
          o_scl_oe = 1'b1;
          o_scl_oe <= #STRETCH_NS 1'b0;
        end
      end else if (stage == 3) begin
        o_sda_oe = !tx[7 - bitn];
      end
    end
  end
endmodule : hstp_target_model

`default_nettype wire

// ===== testbench.sv
// Self-checking bench: host controller against the behavioural register target.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import hstp_pkg::*;
  logic core_clk, resetn, cmd_valid, cmd_read, wr_valid, rd_ready, stretch;
  logic [7:0] cmd_reg, cmd_len, wr_data, o_rd_data;
  logic o_cmd_ready, o_wr_ready, o_rd_valid, o_done, o_nack, o_busy;
  logic m_scl, m_sda, m_scl_oe, m_sda_oe, t_scl_oe, t_sda_oe, scl_w, sda_w;
  logic last_nack, saw_busy;
  logic [7:0] rd_q[$];
  int error_cnt = 0;
  int total_checks = 0;
  int start_cnt = 0;

  // Open-drain lines with pull-ups: an enabled host driver puts its value, the target pulls low.
  assign scl_w = !t_scl_oe && (m_scl_oe ? m_scl : 1'b1);
  assign sda_w = !t_sda_oe && (m_sda_oe ? m_sda : 1'b1);

  hstp_master hstp_master_inst (.i_core_clk(core_clk), .i_resetn(resetn),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(o_cmd_ready), .i_cmd_read(cmd_read),
    .i_cmd_reg(cmd_reg), .i_cmd_len(cmd_len), .i_wr_valid(wr_valid), .o_wr_ready(o_wr_ready),
    .i_wr_data(wr_data), .o_rd_valid(o_rd_valid), .i_rd_ready(rd_ready),
    .o_rd_data(o_rd_data), .o_done(o_done), .o_nack(o_nack), .o_busy(o_busy),
    .i_scl(scl_w), .o_scl(m_scl), .o_scl_oe(m_scl_oe), .i_sda(sda_w), .o_sda(m_sda),
    .o_sda_oe(m_sda_oe));
  hstp_target_model hstp_target_model_inst (.i_scl(scl_w), .i_sda(sda_w),
    .i_stretch(stretch), .o_scl_oe(t_scl_oe), .o_sda_oe(t_sda_oe));

  // Counts start conditions seen on the wire itself.
  always @(negedge sda_w) begin
    if (scl_w === 1'b1) start_cnt++;
  end

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic give_up();
    error_cnt++;
    $display("Wait limit reached at %0t", $time);
    complete_run();
  endtask : give_up

  // Holds each byte until the buffer takes it; a full buffer stalls the loop.
  task automatic push_bytes(input logic [7:0] base, input int cnt);
    int k;
    logic ok;
    wr_valid = 1'b1;
    for (int i = 0; i < cnt; i++) begin
      wr_data = base + 8'(i);
      k = 0;
      // Ready is read once settled; it stands until the edge that takes the byte.
      do begin
        ok = (o_wr_ready === 1'b1);
        @(posedge core_clk);
        #1;
        k++;
      end while (!ok && k < 5000);
      if (!ok) give_up();
    end
    wr_valid = 1'b0;
  endtask : push_bytes

  // One command from take to done, collecting read bytes; stall starves the reader.
  // A read byte still held when done arrives is drained before the task returns.
  task automatic run_cmd(input logic rd, input logic [7:0] rg, input logic [7:0] ln,
                         input logic stall);
    int n;
    logic ok;
    logic fin;
    @(posedge core_clk);
    #1;
    rd_q.delete();
    start_cnt = 0;
    saw_busy = 1'b0;
    fin = 1'b0;
    rd_ready = 1'b1;
    cmd_read = rd;
    cmd_reg = rg;
    cmd_len = ln;
    cmd_valid = 1'b1;
    n = 0;
    do begin
      ok = (o_cmd_ready === 1'b1);
      @(posedge core_clk);
      #1;
      n++;
    end while (!ok && n < 100);
    cmd_valid = 1'b0;
    if (!ok) give_up();
    for (n = 1; n < 40000; n++) begin
      @(posedge core_clk);
      #1;
      saw_busy |= (o_busy === 1'b1);
      if (o_done === 1'b1) fin = 1'b1;
      if (fin && o_rd_valid !== 1'b1) break;
      rd_ready = fin || !stall || (n % 1200 == 0);
      if (o_rd_valid === 1'b1 && rd_ready === 1'b1) rd_q.push_back(o_rd_data);
    end
    if (n >= 40000) give_up();
    last_nack = o_nack;
  endtask : run_cmd

  // Write bytes arrive only after the register byte, so the host must wait on an
  // empty buffer; then the bytes are read back.
  task automatic wr_rd(input logic [7:0] rg, input int cnt, input logic [7:0] base,
                       input logic stall);
    fork
      run_cmd(HSTP_DIR_WRITE, rg, 8'(cnt - 1), 1'b0);
      begin
        repeat (2500) @(posedge core_clk);
        #1;
        push_bytes(base, cnt);
      end
    join
    check(8'(last_nack), 8'h00);
    check(8'(start_cnt), 8'h01);
    check(8'(saw_busy), 8'h01);
    run_cmd(HSTP_DIR_READ, rg, 8'(cnt - 1), stall);
    check(8'(last_nack), 8'h00);
    check(8'(start_cnt), 8'h02);
    check(8'(rd_q.size()), 8'(cnt));
    for (int i = 0; i < cnt; i++) check(rd_q[i], base + 8'(i));
  endtask : wr_rd

  task automatic test_reset();
    repeat (6) @(posedge core_clk);
    check({o_cmd_ready, o_wr_ready, o_busy, m_scl_oe, m_sda_oe, o_rd_valid, o_done, o_nack},
          8'hc0);
    #1 resetn = 1'b1;
    @(posedge core_clk);
    #1;
    check({o_cmd_ready, o_wr_ready, o_busy, m_scl_oe, m_sda_oe, o_rd_valid, o_done, o_nack},
          8'hc0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_write_read();
    wr_rd(8'h02, 3, 8'h5a, 1'b0);
    wr_rd(8'h08, 1, 8'hc3, 1'b0);
    $display("test write_read done");
  endtask : test_write_read

  task automatic test_stretch();
    stretch = 1'b1;
    wr_rd(8'h04, 2, 8'h91, 1'b1);
    stretch = 1'b0;
    $display("test stretch done");
  endtask : test_stretch

  task automatic test_refuse();
    run_cmd(HSTP_DIR_WRITE, 8'h09, 8'h00, 1'b0);
    check(8'(last_nack), 8'h01);
    run_cmd(HSTP_DIR_READ, 8'hff, 8'h00, 1'b0);
    check(8'(last_nack), 8'h01);
    check(8'(start_cnt), 8'h01);
    check(8'(rd_q.size()), 8'h00);
    $display("test refuse done");
  endtask : test_refuse

  task automatic test_fifo();
    push_bytes(8'h30, 16);
    check(8'(o_wr_ready), 8'h00);
    run_cmd(HSTP_DIR_WRITE, 8'h00, 8'h08, 1'b0);
    check(8'(last_nack), 8'h00);
    stretch = 1'b1;
    run_cmd(HSTP_DIR_WRITE, 8'h00, 8'h06, 1'b0);
    stretch = 1'b0;
    check(8'(last_nack), 8'h00);
    check(8'(o_wr_ready), 8'h01);
    run_cmd(HSTP_DIR_READ, 8'h00, 8'h08, 1'b0);
    check(8'(rd_q.size()), 8'h09);
    for (int i = 0; i < 9; i++) check(rd_q[i], 8'h30 + 8'(i < 7 ? i + 9 : i));
    $display("test fifo done");
  endtask : test_fifo

  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_reg = 8'h00;
    cmd_len = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    rd_ready = 1'b1;
    stretch = 1'b0;
    test_reset();
    test_write_read();
    test_stretch();
    test_refuse();
    test_fifo();
    complete_run();
  end
endmodule : testbench

`default_nettype wire
